// ### rtl/acu_defs.svh
// ==========================================================
// Operation
// - stack compare checks all 32 accumulator bits against stack level one.
// - compares never change the accumulator, only the compare flags and, for real compare, the bad pointer flag.
// - each stack compare, and each real compare without a bad pointer, sets exactly one of less, equal, greater.
// - stack compare treats both values as plain unsigned bit patterns.
// - loading the accumulator pushes its old value onto the stack first.
// - real compare checks the float accumulator against a two-word real operand.
// - real ops flag a bad pointer when the pointed operand is invalid.
// - 16-bit add sums a BCD word into the low accumulator half.
// - double add sums an eight-digit BCD operand into the accumulator.
// - after an add, except a real add with a bad pointer, the zero flag shows a zero accumulator.
// - 16-bit carry flag shows carry out of the 16-bit sum.
// - 32-bit carry flag shows carry out of the 32-bit sum.
// - after an add, except a real add with a bad pointer, the negative flag shows a negative accumulator.
// - negative means the accumulator top bit is set.
// - BCD adds flag any summed nibble above nine, in the accumulator or the operand.
// - real add sums an IEEE single value into the float accumulator.
// - bad float flag shows an invalid float left by real add.
// - sign error flag shows a signed add with a wrong sign bit.
// - underflow flag shows a float add underflow.
// - a flag holds until a later op that drives it rewrites it.
`ifndef ACU_DEFS_SVH
`define ACU_DEFS_SVH
// ==========================================================
// register byte offsets
`define ACU_OFS_CMD    8'h00
`define ACU_OFS_OPNDLO 8'h04
`define ACU_OFS_OPNDHI 8'h08
`define ACU_OFS_ACC    8'h0c
`define ACU_OFS_STACK  8'h10
`define ACU_OFS_FLAGS  8'h14
// ==========================================================
// command fields
`define ACU_CMD_PTR    3
`define ACU_CMD_PTR_OK 4
// ==========================================================
// flag bit positions
`define ACU_FL_LESS    0
`define ACU_FL_EQUAL   1
`define ACU_FL_GREATER 2
`define ACU_FL_ZERO    3
`define ACU_FL_C16     4
`define ACU_FL_C32     5
`define ACU_FL_NEG     6
`define ACU_FL_BADPTR  7
`define ACU_FL_BADFLT  8
`define ACU_FL_SIGNERR 9
`define ACU_FL_UNDER   10
`define ACU_FL_BADBCD  11
`define ACU_NFLAGS     12
// ==========================================================
// reset values and sizes
`define ACU_FLAGS_RST  12'h000
`define ACU_WORD_RST   32'h0000_0000
`define ACU_STACK_DEPTH 4
`define ACU_FP_QNAN    32'h7fc0_0000
`endif

// ### rtl/acu_pkg.sv
package acu_pkg;
  typedef enum logic [2:0] {
    acu_op_none   = 3'b000,
    acu_op_scmp   = 3'b001,
    acu_op_rcmp   = 3'b010,
    acu_op_add16  = 3'b011,
    acu_op_dadd   = 3'b100,
    acu_op_radd   = 3'b101
  } acu_op_t;
  typedef enum logic {
    acu_st_idle   = 1'b0,
    acu_st_answer = 1'b1
  } acu_bus_st_t;
endpackage : acu_pkg

// ### rtl/acu_math_if.sv
`timescale 1ns/100ps
interface acu_math_if;
  logic [31:0] acc;
  logic [31:0] opnd;
  logic [31:0] bsum;
  logic        c16;
  logic        c32;
  logic        bad16;
  logic        bad32;
  logic [31:0] fsum;
  logic        fbad;
  logic        funder;
  logic        fsign_err;
  modport top  (output acc, opnd,
                input  bsum, c16, c32, bad16, bad32, fsum, fbad, funder, fsign_err);
  modport math (input  acc, opnd,
                output bsum, c16, c32, bad16, bad32, fsum, fbad, funder, fsign_err);
endinterface : acu_math_if

// ### rtl/acu_math.sv
`timescale 1ns/100ps
`include "acu_defs.svh"
module acu_math (
  // operands in, sums and conditions out
  acu_math_if.math m
);
  // ==========================================================
  // bcd digit chain
  logic [8:0]  dc;
  logic [7:0]  bad_a;
  logic [7:0]  bad_b;
  assign dc[0] = 1'b0;
  genvar i;
  generate
    for (i = 0; i < 8; i++) begin : g_dig
      logic [4:0] raw;
      assign raw = {1'b0, m.acc[4*i+:4]} + {1'b0, m.opnd[4*i+:4]} + {4'h0, dc[i]};
      // decimal adjust: skip the six unused codes
      assign dc[i+1]          = raw > 5'h09;
      assign m.bsum[4*i+:4]   = dc[i+1] ? 4'(raw + 5'h06) : raw[3:0];
      assign bad_a[i]         = m.acc[4*i+:4] > 4'h9;
      assign bad_b[i]         = m.opnd[4*i+:4] > 4'h9;
    end
  endgenerate
  assign m.c16   = dc[4];
  assign m.c32   = dc[8];
  assign m.bad16 = |{bad_a[3:0], bad_b[3:0]};
  assign m.bad32 = |{bad_a, bad_b};

  // ==========================================================
  // single precision add, truncating, denormals flushed
  logic [31:0]        big;
  logic [31:0]        sml;
  logic [7:0]         diff;
  logic [23:0]        mb;
  logic [23:0]        ms;
  logic [24:0]        sum;
  logic signed [9:0]  e;
  logic [31:0]        res;
  always_comb begin
    big = m.acc;
    sml = m.opnd;
    if (m.opnd[30:0] > m.acc[30:0]) begin
      big = m.opnd;
      sml = m.acc;
    end
    diff = big[30:23] - sml[30:23];
    mb   = (big[30:23] == 8'h00) ? 24'h0 : {1'b1, big[22:0]};
    ms   = (sml[30:23] == 8'h00) ? 24'h0 : {1'b1, sml[22:0]};
    ms   = (diff > 8'd24) ? 24'h0 : (ms >> diff);
    sum  = (big[31] == sml[31]) ? ({1'b0, mb} + {1'b0, ms}) : ({1'b0, mb} - {1'b0, ms});
    e    = {2'b00, big[30:23]};
    m.funder = 1'b0;
    if (sum[24]) begin
      sum = sum >> 1;
      e   = e + 10'sd1;
    end
    // normalise; bounded so it unrolls to a fixed shifter
    for (int k = 0; k < 24; k++) begin
      if (!sum[23] && sum != 25'h0) begin
        sum = sum << 1;
        e   = e - 10'sd1;
      end
    end
    if (big[30:23] == 8'hff || sml[30:23] == 8'hff)
      res = `ACU_FP_QNAN;
    else if (sum == 25'h0)
      res = `ACU_WORD_RST;
    else if (e >= 10'sd255)
      res = {big[31], 8'hff, 23'h0};
    else if (e <= 10'sd0) begin
      res      = `ACU_WORD_RST;
      m.funder = 1'b1;
    end else
      res = {big[31], e[7:0], sum[22:0]};
    m.fsum      = res;
    m.fbad      = res[30:23] == 8'hff;
    m.fsign_err = (m.acc[31] == m.opnd[31]) && (res[31] != m.acc[31])
                  && (res[30:0] != 31'h0);
  end
endmodule : acu_math

// ### rtl/acu_top.sv
`timescale 1ns/100ps
`include "acu_defs.svh"
module acu_top (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rstn,
  // avalon-mm slave
  input  wire logic [7:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  // flag consumers
  output logic [11:0]      status_flags
);
  // ==========================================================
  // state
  logic [31:0]          acc;
  logic [31:0]          stack [`ACU_STACK_DEPTH];
  logic [11:0]          flags;
  logic [15:0]          opnd_lo;
  logic [15:0]          opnd_hi;
  logic [4:0]           cmd_last;
  acu_pkg::acu_bus_st_t bus_st;
  logic                 req;
  logic                 take;
  logic                 exec;
  acu_pkg::acu_op_t     exec_op;
  logic                 ptr_bad;
  logic                 acc_load;
  logic                 less;
  logic                 equal;
  logic [31:0]          fka;
  logic [31:0]          fkb;
  logic [31:0]          opnd;

  acu_math_if mif ();
  acu_math u_math (
    .m (mif.math)
  );

  // two consecutive operand words form one 32-bit operand
  assign opnd     = {opnd_hi, opnd_lo};
  assign mif.acc  = acc;
  assign mif.opnd = opnd;

  // ==========================================================
  // bus handshake: one wait cycle, then the answer
  assign req             = avs_read | avs_write;
  assign avs_waitrequest = req && (bus_st == acu_pkg::acu_st_idle);
  assign take            = req && (bus_st == acu_pkg::acu_st_answer);
  assign exec     = take && avs_write && (avs_address == `ACU_OFS_CMD);
  assign exec_op  = acu_pkg::acu_op_t'(avs_writedata[2:0]);
  assign ptr_bad  = avs_writedata[`ACU_CMD_PTR] && !avs_writedata[`ACU_CMD_PTR_OK];
  assign acc_load = take && avs_write && (avs_address == `ACU_OFS_ACC);

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      bus_st <= acu_pkg::acu_st_idle;
    end else begin
      case (bus_st)
        acu_pkg::acu_st_idle:   bus_st <= req ? acu_pkg::acu_st_answer : acu_pkg::acu_st_idle;
        acu_pkg::acu_st_answer: bus_st <= acu_pkg::acu_st_idle;
        default:                bus_st <= acu_pkg::acu_st_idle;
      endcase
    end
  end

  // read data is captured in the wait cycle so it stands at the taking edge
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      avs_readdata <= `ACU_WORD_RST;
    end else if (avs_read && bus_st == acu_pkg::acu_st_idle) begin
      case (avs_address)
        `ACU_OFS_CMD:    avs_readdata <= {27'h0, cmd_last};
        `ACU_OFS_OPNDLO: avs_readdata <= {16'h0, opnd_lo};
        `ACU_OFS_OPNDHI: avs_readdata <= {16'h0, opnd_hi};
        `ACU_OFS_ACC:    avs_readdata <= acc;
        `ACU_OFS_STACK:  avs_readdata <= stack[0];
        `ACU_OFS_FLAGS:  avs_readdata <= {20'h0, flags};
        default:         avs_readdata <= `ACU_WORD_RST;
      endcase
    end
  end

  // ==========================================================
  // operand and command registers
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      opnd_lo  <= 16'h0000;
      opnd_hi  <= 16'h0000;
      cmd_last <= 5'h00;
    end else if (take && avs_write) begin
      if (avs_address == `ACU_OFS_OPNDLO)
        opnd_lo <= avs_writedata[15:0];
      if (avs_address == `ACU_OFS_OPNDHI)
        opnd_hi <= avs_writedata[15:0];
      if (avs_address == `ACU_OFS_CMD)
        cmd_last <= avs_writedata[4:0];
    end
  end

  // ==========================================================
  // accumulator stack: pushed only by a load, never popped here
  genvar g;
  generate
    for (g = 0; g < `ACU_STACK_DEPTH; g++) begin : g_stk
      always_ff @(posedge clk or negedge rstn) begin
        if (!rstn)
          stack[g] <= `ACU_WORD_RST;
        else if (acc_load)
          stack[g] <= (g == 0) ? acc : stack[(g == 0) ? 0 : g - 1];
      end
    end
  endgenerate

  // ==========================================================
  // accumulator
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      acc <= `ACU_WORD_RST;
    end else if (acc_load) begin
      acc <= avs_writedata;
    end else if (exec) begin
      // compares fall through to default and leave acc alone
      case (exec_op)
        acu_pkg::acu_op_add16: acc <= {acc[31:16], mif.bsum[15:0]};
        acu_pkg::acu_op_dadd:  acc <= mif.bsum;
        acu_pkg::acu_op_radd:  acc <= ptr_bad ? acc : mif.fsum;
        default:               acc <= acc;
      endcase
    end
  end

  // ==========================================================
  // compare results
  function automatic logic [31:0] fkey(input logic [31:0] v);
    // map float onto an unsigned order; both zeros meet in the middle
    if (v[30:0] == 31'h0)
      fkey = 32'h8000_0000;
    else
      fkey = v[31] ? ~v : {1'b1, v[30:0]};
  endfunction : fkey

  assign fka = fkey(acc);
  assign fkb = fkey(opnd);
  always_comb begin
    if (exec_op == acu_pkg::acu_op_rcmp) begin
      less  = fka < fkb;
      equal = fka == fkb;
    end else begin
      less  = acc < stack[0];
      equal = acc == stack[0];
    end
  end

  // ==========================================================
  // flags: each op rewrites only the flags it drives
  logic [31:0] nres;
  always_comb begin
    case (exec_op)
      acu_pkg::acu_op_add16: nres = {acc[31:16], mif.bsum[15:0]};
      acu_pkg::acu_op_dadd:  nres = mif.bsum;
      default:               nres = mif.fsum;
    endcase
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      flags <= `ACU_FLAGS_RST;
    end else if (exec) begin
      case (exec_op)
        acu_pkg::acu_op_scmp, acu_pkg::acu_op_rcmp: begin
          if (exec_op == acu_pkg::acu_op_rcmp)
            flags[`ACU_FL_BADPTR] <= ptr_bad;
          // a bad pointer leaves no operand to compare against
          if (!(exec_op == acu_pkg::acu_op_rcmp && ptr_bad)) begin
            flags[`ACU_FL_LESS]    <= less;
            flags[`ACU_FL_EQUAL]   <= equal;
            flags[`ACU_FL_GREATER] <= !less && !equal;
          end
        end
        acu_pkg::acu_op_add16, acu_pkg::acu_op_dadd: begin
          flags[`ACU_FL_ZERO]   <= nres == 32'h0;
          flags[`ACU_FL_NEG]    <= nres[31];
          flags[`ACU_FL_C16]    <= mif.c16;
          flags[`ACU_FL_C32]    <= (exec_op == acu_pkg::acu_op_dadd) && mif.c32;
          flags[`ACU_FL_BADBCD] <= (exec_op == acu_pkg::acu_op_dadd) ? mif.bad32
                                                                     : mif.bad16;
        end
        acu_pkg::acu_op_radd: begin
          flags[`ACU_FL_BADPTR] <= ptr_bad;
          if (!ptr_bad) begin
            flags[`ACU_FL_ZERO]    <= nres[30:0] == 31'h0;
            flags[`ACU_FL_NEG]     <= nres[31];
            flags[`ACU_FL_BADFLT]  <= mif.fbad;
            flags[`ACU_FL_SIGNERR] <= mif.fsign_err;
            flags[`ACU_FL_UNDER]   <= mif.funder;
          end
        end
        default: flags <= flags;
      endcase
    end
  end
  assign status_flags = flags;

  // ==========================================================
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  logic is_cmp;
  logic is_add;
  assign is_cmp = exec && (exec_op == acu_pkg::acu_op_scmp || exec_op == acu_pkg::acu_op_rcmp);
  assign is_add = exec && (exec_op == acu_pkg::acu_op_add16 || exec_op == acu_pkg::acu_op_dadd);

  chk_cmp_onehot: assert property (
    exec && exec_op == acu_pkg::acu_op_scmp |=> $onehot(flags[2:0]))
    else $error("compare flags not one-hot");
  chk_cmp_acc_kept: assert property (
    is_cmp |=> acc == $past(acc))
    else $error("compare changed accumulator");
  chk_cmp_stack_kept: assert property (
    is_cmp |=> stack[0] == $past(stack[0]) && stack[1] == $past(stack[1]))
    else $error("compare moved the stack");
  chk_scmp_order: assert property (
    exec && exec_op == acu_pkg::acu_op_scmp |=>
      flags[`ACU_FL_LESS] == ($past(acc) < $past(stack[0])))
    else $error("stack compare order wrong");
  chk_load_push: assert property (
    acc_load |=> stack[0] == $past(acc) && stack[1] == $past(stack[0]))
    else $error("load did not push");
  chk_add_zero_neg: assert property (
    is_add |=> flags[`ACU_FL_ZERO] == (acc == 32'h0) && flags[`ACU_FL_NEG] == acc[31])
    else $error("zero or negative flag wrong");
  chk_add16_carry: assert property (
    exec && exec_op == acu_pkg::acu_op_add16 && mif.c16 |=>
      flags[`ACU_FL_C16] && acc[31:16] == $past(acc[31:16]))
    else $error("16-bit carry lost");
  chk_dadd_carry: assert property (
    exec && exec_op == acu_pkg::acu_op_dadd |=> flags[`ACU_FL_C32] == $past(mif.c32))
    else $error("32-bit carry wrong");
  chk_bad_ptr: assert property (
    exec && exec_op == acu_pkg::acu_op_radd && ptr_bad |=>
      flags[`ACU_FL_BADPTR] && $stable(acc))
    else $error("bad pointer not handled");
  chk_flag_hold: assert property (
    !exec |=> $stable(flags))
    else $error("flags moved without an op");
  chk_bus_answer: assert property (
    req && bus_st == acu_pkg::acu_st_idle |-> avs_waitrequest ##1 !avs_waitrequest)
    else $error("answer not after one wait");

  chk_rcmp_onehot: assert property (
    exec && exec_op == acu_pkg::acu_op_rcmp && !ptr_bad |=> $onehot(flags[2:0]))
    else $error("real compare flags not one-hot");

  chk_rcmp_bad_ptr: assert property (
    exec && exec_op == acu_pkg::acu_op_rcmp && ptr_bad |=>
      flags[`ACU_FL_BADPTR] && $stable(flags[2:0]))
    else $error("real compare bad pointer not handled");

  chk_add16_c32_clear: assert property (
    exec && exec_op == acu_pkg::acu_op_add16 |=> !flags[`ACU_FL_C32])
    else $error("16-bit add set the 32-bit carry");

  chk_dadd_bad_digit: assert property (
    exec && exec_op == acu_pkg::acu_op_dadd && opnd[31:28] > 4'h9 |=>
      flags[`ACU_FL_BADBCD])
    else $error("non-decimal digit not flagged");

  chk_radd_under: assert property (
    exec && exec_op == acu_pkg::acu_op_radd && !ptr_bad && mif.funder |=>
      flags[`ACU_FL_UNDER] && flags[`ACU_FL_ZERO])
    else $error("underflow not flagged");

  chk_radd_bad_float: assert property (
    exec && exec_op == acu_pkg::acu_op_radd && !ptr_bad |=>
      flags[`ACU_FL_BADFLT] == (acc[30:23] == 8'hff))
    else $error("invalid float flag wrong");

  chk_load_value: assert property (
    acc_load |=> acc == $past(avs_writedata))
    else $error("load did not take the value");

  cov_scmp_less: cover property (exec && exec_op == acu_pkg::acu_op_scmp && less);
  cov_rcmp_bad_ptr: cover property (exec && exec_op == acu_pkg::acu_op_rcmp && ptr_bad);
  cov_add16_carry: cover property (exec && exec_op == acu_pkg::acu_op_add16 && mif.c16);
  cov_dadd_carry: cover property (exec && exec_op == acu_pkg::acu_op_dadd && mif.c32);
  cov_radd_under: cover property (exec && exec_op == acu_pkg::acu_op_radd && mif.funder);
endmodule : acu_top

// ### dv/acu_seq_model.sv
`timescale 1ns/100ps
`include "acu_defs.svh"
module acu_seq_model (
  // clock
  input  wire logic        clk,
  // avalon-mm master
  output logic [7:0]       avs_address,
  output logic             avs_read,
  output logic             avs_write,
  output logic [31:0]      avs_writedata,
  input  wire logic [31:0] avs_readdata,
  input  wire logic        avs_waitrequest
);
  // ==========================================================
  // word operand memory
  logic [15:0] mem [16];
  int          bus_waits;

  initial begin
    avs_address   = 8'h00;
    avs_read      = 1'b0;
    avs_write     = 1'b0;
    avs_writedata = 32'h0000_0000;
    bus_waits     = 0;
  end

  // ==========================================================
  // one transfer: entered just after a rising edge; waitrequest and read
  // data are taken as they stood at each rising edge, never in between
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    logic w;
    int   n;
    avs_address   <= a;
    avs_writedata <= d;
    avs_write     <= wr;
    avs_read      <= ~wr;
    n = 0;
    do begin
      @(posedge clk);
      w = avs_waitrequest;
      q = avs_readdata;
      n++;
    end while (w !== 1'b0 && n < 64);
    if (n >= 64) bus_waits++;
    avs_write     <= 1'b0;
    avs_read      <= 1'b0;
    // released lines show a changed pattern, never the last request
    avs_address   <= ~a;
    avs_writedata <= ~d;
    @(posedge clk);
  endtask : xfer

  // operands only from two consecutive words, never immediate
  task automatic exec(input logic [2:0] op, input int adr, input logic ptr, input logic ok);
    logic [31:0] q;
    xfer(1'b1, `ACU_OFS_OPNDLO, {16'h0000, mem[adr]}, q);
    xfer(1'b1, `ACU_OFS_OPNDHI, {16'h0000, mem[adr+1]}, q);
    xfer(1'b1, `ACU_OFS_CMD, {27'h0, ok, ptr, op}, q);
  endtask : exec
endmodule : acu_seq_model

// ### dv/accumulator_compare_add_unit_bench.sv
`timescale 1ns/100ps
`include "acu_defs.svh"
module accumulator_compare_add_unit_bench;
  logic        clk, rstn, avs_read, avs_write, avs_waitrequest, uacc, r_u9;
  logic [7:0]  avs_address;
  logic [31:0] avs_writedata, avs_readdata, rd, acc, lfsr, a, b, r_sum;
  logic [11:0] status_flags, ef, unk, r_fl;
  logic [31:0] stk[$];
  int          miscompares, check_count;
  localparam logic [63:0] RC [4] = '{64'h40e00000_40c00000, 64'h40c00000_40e00000,
                                     64'h00000000_80000000, 64'hc0e00000_40c00000};
  localparam logic [31:0] AI [4] = '{32'h80009999, 32'h00009999, 32'h99999999, 32'h99990000};
  localparam logic [31:0] BI [4] = '{32'h1, 32'h1, 32'h1, 32'h00010000};
  localparam logic [31:0] RA [6] = '{32'h3f800000, 32'h0, 32'hc0400000, 32'h7f800000,
                                     32'h00800001, 32'h3f800000};
  localparam logic [31:0] RB [6] = '{32'h40000000, 32'h0, 32'h3f800000, 32'h3f800000,
                                     32'h80800000, 32'h40000000};
  localparam logic [31:0] RS [6] = '{32'h40400000, 32'h0, 32'hc0000000, 32'h7fc00000,
                                     32'h0, 32'h0};
  localparam logic [11:0] RF [6] = '{12'h000, 12'h008, 12'h040, 12'h100, 12'h408, 12'h000};
  localparam logic        RU [6] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0};

  acu_top dut (.clk(clk), .rstn(rstn), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .status_flags(status_flags));
  acu_seq_model seq (.clk(clk), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest));

  initial clk = 1'b0;
  always #2 clk = ~clk;

  // ==========================================================
  // reference model helpers
  function automatic logic [31:0] rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr;
  endfunction : rnd
  function automatic logic [31:0] rbcd(input logic [31:0] v);
    logic [31:0] r;
    for (int i = 0; i < 8; i++) r[4*i+:4] = (v[4*i+:4] > 4'h9) ? v[4*i+:4] - 4'h6 : v[4*i+:4];
    return r;
  endfunction : rbcd
  function automatic logic nbad(input logic [31:0] v, input int nd);
    logic r;
    r = 1'b0;
    for (int i = 0; i < nd; i++) r |= (v[4*i+:4] > 4'h9);
    return r;
  endfunction : nbad
  function automatic logic [33:0] bcd(input logic [31:0] x, input logic [31:0] y, input int nd);
    logic [31:0] s;
    logic [4:0]  d;
    logic        c, c16;
    s = x;
    c = 1'b0;
    c16 = 1'b0;
    for (int i = 0; i < nd; i++) begin
      d = x[4*i+:4] + y[4*i+:4] + c;
      c = d > 5'd9;
      s[4*i+:4] = 4'(c ? d - 5'd10 : d);
      if (i == 3) c16 = c;
    end
    return {c & (nd == 8), c16, s};
  endfunction : bcd
  // ieee order, so +0 equals -0
  function automatic logic [2:0] fcmp(input logic [31:0] x, input logic [31:0] y);
    longint kx, ky;
    kx = x[31] ? -longint'(x[30:0]) : longint'(x[30:0]);
    ky = y[31] ? -longint'(y[30:0]) : longint'(y[30:0]);
    return {kx > ky, kx == ky, kx < ky};
  endfunction : fcmp

  // ==========================================================
  // checks and bus helpers
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic rchk(input logic [7:0] ad, input logic [31:0] e);
    seq.xfer(1'b0, ad, 32'h0, rd);
    chk(rd, e);
  endtask : rchk
  task automatic load(input logic [31:0] v);
    seq.xfer(1'b1, `ACU_OFS_ACC, v, rd);
    seq.xfer(1'b0, `ACU_OFS_STACK, 32'h0, rd);
    if (!uacc) chk(rd, acc);
    stk.push_front(acc);
    void'(stk.pop_back());
    acc = v;
    uacc = 1'b0;
  endtask : load
  // sums with a non-decimal digit leave acc, zero, carries and sign open
  task automatic run(input logic [2:0] op, input logic [31:0] o, input logic p, input logic k);
    logic [33:0] s;
    logic        bp;
    seq.mem[0] = o[15:0];
    seq.mem[1] = o[31:16];
    seq.exec(op, 0, p, k);
    bp = p & ~k;
    case (op)
      acu_pkg::acu_op_scmp: ef[2:0] = {acc > stk[0], acc == stk[0], acc < stk[0]};
      acu_pkg::acu_op_rcmp: begin
        ef[7] = bp;
        if (!bp) ef[2:0] = fcmp(acc, o);
      end
      acu_pkg::acu_op_radd: begin
        ef[7] = bp;
        if (!bp) begin
          acc = r_sum;
          ef = (ef & ~12'h748) | r_fl;
          unk = (unk & 12'h030) | {2'b00, r_u9, 9'h000};
        end
      end
      default: begin
        s = bcd(acc, o, (op == acu_pkg::acu_op_dadd) ? 8 : 4);
        ef[11] = nbad(acc, (op == acu_pkg::acu_op_dadd) ? 8 : 4) |
                 nbad(o, (op == acu_pkg::acu_op_dadd) ? 8 : 4);
        acc = s[31:0];
        ef[5:4] = s[33:32];
        ef[3] = acc == 32'h0;
        ef[6] = acc[31];
        unk = ef[11] ? (unk | 12'h078) : (unk & ~12'h078);
        uacc = ef[11];
      end
    endcase
    seq.xfer(1'b0, `ACU_OFS_ACC, 32'h0, rd);
    if (!uacc) chk(rd, acc);
    chk({20'h0, status_flags & ~unk}, {20'h0, ef & ~unk});
  endtask : run
  task automatic wrap_up();
    miscompares += seq.bus_waits;
    $display("checks %0d miscompares %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : wrap_up

  initial begin
    #100000;
    miscompares++;
    wrap_up();
  end

  // ==========================================================
  // main sequence
  initial begin
    rstn = 1'b0;
    lfsr = 32'h75d6be4b;
    {acc, ef, unk, uacc, r_sum, r_fl, r_u9} = '0;
    {miscompares, check_count} = '0;
    stk = '{32'h0, 32'h0, 32'h0, 32'h0};
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    chk({20'h0, status_flags}, 32'h0);
    seq.xfer(1'b1, 8'h3c, 32'hffff_ffff, rd);
    seq.xfer(1'b1, `ACU_OFS_FLAGS, 32'h0000_0fff, rd);
    seq.xfer(1'b1, `ACU_OFS_STACK, 32'h1234_5678, rd);
    rchk(8'h3c, 32'h0);
    rchk(`ACU_OFS_FLAGS, 32'h0);
    rchk(`ACU_OFS_STACK, 32'h0);
    rchk(`ACU_OFS_ACC, 32'h0);
    for (int i = 0; i < 12; i++) begin
      b = rnd();
      a = (i % 3 == 0) ? b : rnd();
      if (i == 1) {a, b} = {32'hffff_ffff, 32'h0};
      if (i == 2) {a, b} = {32'h0, 32'hffff_ffff};
      load(b);
      load(a);
      run(acu_pkg::acu_op_scmp, rnd(), 1'b0, 1'b0);
      rchk(`ACU_OFS_STACK, b);
    end
    for (int i = 0; i < 10; i++) begin
      a = rnd() & 32'hbfff_ffff;
      b = rnd() & 32'hbfff_ffff;
      if (i < 4) {a, b} = RC[i];
      load(a);
      run(acu_pkg::acu_op_rcmp, b, i == 4 || i == 5, i == 5);
    end
    for (int k = 0; k < 2; k++) begin
      for (int i = 0; i < 10; i++) begin
        if (i < 2) load(AI[k*2+i]);
        b = (i < 2) ? BI[k*2+i] : rbcd(rnd());
        run(k ? acu_pkg::acu_op_dadd : acu_pkg::acu_op_add16, b, 1'b0, 1'b0);
      end
    end
    load(32'h0000_1234);
    run(acu_pkg::acu_op_add16, 32'h0000_00b0, 1'b0, 1'b0);
    load(32'h0);
    run(acu_pkg::acu_op_dadd, 32'hb000_0000, 1'b0, 1'b0);
    load(32'h1);
    load(32'h2);
    for (int i = 0; i < 6; i++) begin
      load(RA[i]);
      {r_sum, r_fl, r_u9} = {RS[i], RF[i], RU[i]};
      run(acu_pkg::acu_op_radd, RB[i], i == 5, 1'b0);
    end
    seq.xfer(1'b0, `ACU_OFS_FLAGS, 32'h0, rd);
    chk(rd & {20'h0, ~unk}, {20'h0, ef & ~unk});
    wrap_up();
  end
endmodule : accumulator_compare_add_unit_bench
